// ==== core/lsa_pkg.sv ====
// Constants, field layout and state type of the linear sweep engine
// Functional notes
// - Auxiliary accumulator sweeps only with enable bit
// - Destination bits pick frequency or phase
// - Trigger bit picks edge or level start
// - Level trigger restarts sweep while pin high
// - Start and end limits from limit register
// - Phase limits MSB aligned, low bits ignored
// - Profile low bits: off, up, down, both
// - Parallel port uses internal profile bits only
// - Serial port: select bit picks bits or pins
// - Step words 32 or 14 bits, intervals 16
// - Rising words upward, falling words downward
// - No-dwell bit returns accumulator to zero at end of up-mode sweep only
// - New step and interval words apply mid-sweep
// - Each step but the first after a trigger or turn lasts interval word clock cycles
// - Upward sweep accumulates until upper limit
// - Downward sweep accumulates until lower limit
// - Continuous clear holds accumulator at zero
// - Auxiliary auto-clear pulses on strobe or profile change
// - Phase auto-clear pulses on strobe or profile change
// - Clear-and-release repeats until bit cleared
// - Both accumulators cleared independently
// - Profile from internal bits or three pins
// - Pins are profile source after reset
package lsa_pkg;
	localparam logic [7:0] ADDR_SWEEP_LIMITS = 8'h06;
	localparam logic [7:0] ADDR_SWEEP_STEP_WORDS = 8'h07;
	localparam logic [7:0] ADDR_SWEEP_STEP_INTERVALS = 8'h08;
	localparam int CONTROL_FUNCTION_REG_ONE_W = 32;
	localparam int CONTROL_FUNCTION_REG_ONE_NO_DWELL = 8;
	localparam int CONTROL_FUNCTION_REG_ONE_TRIG_LEVEL = 9;
	localparam int CONTROL_FUNCTION_REG_ONE_AUX_EN = 11;
	localparam int CONTROL_FUNCTION_REG_ONE_DEST_LO = 12;
	localparam int CONTROL_FUNCTION_REG_ONE_DEST_HI = 13;
	localparam int CONTROL_FUNCTION_REG_ONE_AUTO_CLR_AUX = 14;
	localparam int CONTROL_FUNCTION_REG_ONE_AUTO_CLR_PHASE = 15;
	localparam int CONTROL_FUNCTION_REG_ONE_CONT_CLR_AUX = 18;
	localparam int CONTROL_FUNCTION_REG_ONE_CONT_CLR_PHASE = 19;
	localparam int CONTROL_FUNCTION_REG_ONE_PROF_LO = 20;
	localparam int CONTROL_FUNCTION_REG_ONE_PROF_HI = 22;
	localparam int CONTROL_FUNCTION_REG_ONE_PROF_INTERNAL = 27;
	localparam logic [31:0] CONTROL_FUNCTION_REG_ONE_RESET = 32'h0000_0000;
	localparam int FREQ_W = 32;
	localparam int PHASE_W = 14;
	localparam int IVAL_W = 16;
	localparam int LIM_START_LO = 0;
	localparam int LIM_END_LO = 32;
	localparam int STEP_RISE_LO = 0;
	localparam int STEP_FALL_LO = 32;
	localparam int IVAL_RISE_LO = 0;
	localparam int IVAL_FALL_LO = 16;
	localparam logic [31:0] PHASE_MASK = 32'hFFFC_0000;
	localparam logic [31:0] FREQ_MASK = 32'hFFFF_FFFF;
	localparam logic [1:0] DEST_PHASE = 2'h1;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_UP = 2'h1;
	localparam logic [1:0] MODE_DOWN = 2'h2;
	localparam logic [1:0] MODE_BIDIR = 2'h3;
	typedef enum logic [1:0] {
		LSA_IDLE = 2'b00,
		LSA_RISE = 2'b01,
		LSA_FALL = 2'b10,
		LSA_DONE = 2'b11
	} lsa_state_type;
endpackage

// ==== core/lsa_clr_if.sv ====
// Clear control bundle between the sweep top and a clear controller
`timescale 1ns/1ps
interface lsa_clr_if;
	logic cont;
	logic auto_en;
	logic evt;
	logic clr;
	modport ctrl (input cont, input auto_en, input evt, output clr);
	modport user (output cont, output auto_en, output evt, input clr);
endinterface

// ==== core/lsa_clear_ctrl.sv ====
// Continuous clear and clear-and-release for one accumulator
`timescale 1ns/1ps
module lsa_clear_ctrl (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	lsa_clr_if.ctrl port
);
	// One clear pulse per event while auto is set; level while continuous
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			port.clr <= 1'b0;
		else if (ce)
			port.clr <= port.cont | (port.auto_en & port.evt);
	end
endmodule

// ==== core/lsa_rate_timer.sv ====
// Dwell timer that paces sweep steps
`timescale 1ns/1ps
module lsa_rate_timer #(
	parameter int WIDTH = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic run,
	input wire logic load,
	input wire logic [WIDTH-1:0] interval,
	output logic step
);
	logic [WIDTH-1:0] cnt;
	logic [WIDTH-1:0] reload;

	// A zero interval behaves as one cycle, the shortest dwell
	assign reload = (interval == '0) ? '0 : interval - 1'b1;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			step <= 1'b0;
		end
		else if (ce)
		begin
			if (!run)
			begin
				cnt <= '0;
				step <= 1'b0;
			end
			else if (load)
			begin
				cnt <= reload;
				step <= 1'b0;
			end
			else if (cnt == '0)
			begin
				// Reload from the live word so rewrites shape later steps
				cnt <= reload;
				step <= 1'b1;
			end
			else
			begin
				cnt <= cnt - 1'b1;
				step <= 1'b0;
			end
		end
	end
endmodule

// ==== core/lsa_sweep.sv ====
// Linear sweep engine: auxiliary accumulator, profile decode, clears
`timescale 1ns/1ps
module lsa_sweep (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [31:0] control_function_reg_one_in,
	input wire logic [63:0] sweep_limits,
	input wire logic [63:0] sweep_step_words,
	input wire logic [31:0] sweep_step_intervals,
	input wire logic register_transfer_strobe,
	input wire logic [2:0] profile_select_pins,
	input wire logic parallel_port_mode,
	input wire logic [31:0] tuning_word,
	input wire logic [13:0] phase_offset_word,
	output logic [31:0] freq_word_out,
	output logic [13:0] phase_word_out,
	output logic [31:0] aux_acc_out,
	output logic [2:0] profile_active,
	output logic sweep_running,
	output logic sweep_falling,
	output logic sweep_complete,
	output logic aux_wrapped,
	output logic phase_acc_clear
);
	localparam int FW = lsa_pkg::FREQ_W;
	localparam int PW = lsa_pkg::PHASE_W;
	localparam int IW = lsa_pkg::IVAL_W;

	// Active copies, taken on the transfer strobe
	logic [31:0] control_function_reg_one;
	logic [63:0] limits;
	logic [63:0] steps;
	logic [31:0] ivals;

	logic [2:0] prof_int;
	logic use_internal;
	logic [2:0] prof_sel;
	logic [2:0] prof_prev;
	logic prof_chg;
	logic clr_evt;
	logic [1:0] mode;
	logic [1:0] mode_prev;
	logic [1:0] dest;
	logic is_phase;
	logic sweep_en;
	logic level_trig;
	logic no_dwell;
	logic trig;
	logic [31:0] mask;
	logic [31:0] start_pt;
	logic [31:0] end_pt;
	logic [31:0] rise_step;
	logic [31:0] fall_step;
	logic [IW-1:0] rise_ival;
	logic [IW-1:0] fall_ival;
	logic [31:0] sum_up;
	logic [31:0] diff_dn;
	logic [31:0] above_start;

	lsa_pkg::lsa_state_type state;
	lsa_pkg::lsa_state_type next_state;
	logic [31:0] acc;
	logic [31:0] next_acc;
	logic tmr_load;
	logic load_fall;
	logic tmr_run;
	logic [IW-1:0] tmr_ival;
	logic step;
	logic clr_evt_q;
	logic wrap_now;

	lsa_clr_if aux_clr ();
	lsa_clr_if ph_clr ();

	// Registers take effect together on the strobe, so a sweep in flight
	// picks up rewritten words at its next step
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			control_function_reg_one <= lsa_pkg::CONTROL_FUNCTION_REG_ONE_RESET;
			limits <= '0;
			steps <= '0;
			ivals <= '0;
		end
		else if (ce && register_transfer_strobe)
		begin
			control_function_reg_one <= control_function_reg_one_in;
			limits <= sweep_limits;
			steps <= sweep_step_words;
			ivals <= sweep_step_intervals;
		end
	end

	assign prof_int = control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_PROF_HI:lsa_pkg::CONTROL_FUNCTION_REG_ONE_PROF_LO];
	// Parallel port forces the internal bits; serial lets the select bit choose
	assign use_internal = parallel_port_mode | control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_PROF_INTERNAL];
	assign prof_sel = use_internal ? prof_int : profile_select_pins;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			prof_prev <= 3'h0;
		else if (ce)
			prof_prev <= prof_sel;
	end

	assign prof_chg = (prof_sel != prof_prev);
	assign clr_evt = register_transfer_strobe | prof_chg;
	// Event waits a cycle so the strobe that sets an auto bit already clears
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			clr_evt_q <= 1'b0;
		else if (ce)
			clr_evt_q <= clr_evt;
	end
	// Top profile bit does not steer the sweep
	assign mode = prof_sel[1:0];
	assign mode_prev = prof_prev[1:0];

	assign dest = control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_DEST_HI:lsa_pkg::CONTROL_FUNCTION_REG_ONE_DEST_LO];
	assign is_phase = (dest == lsa_pkg::DEST_PHASE);
	assign sweep_en = control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_AUX_EN];
	assign level_trig = control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_TRIG_LEVEL];
	assign no_dwell = control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_NO_DWELL];

	// Level trigger holds while the mode is on; edge trigger needs entry
	assign trig = level_trig ? (mode != lsa_pkg::MODE_OFF) :
		((mode != lsa_pkg::MODE_OFF) && (mode != mode_prev));

	// Phase words keep only their 14 upper bits
	assign mask = is_phase ? lsa_pkg::PHASE_MASK : lsa_pkg::FREQ_MASK;
	assign start_pt = limits[lsa_pkg::LIM_START_LO +: FW] & mask;
	assign end_pt = limits[lsa_pkg::LIM_END_LO +: FW] & mask;
	assign rise_step = steps[lsa_pkg::STEP_RISE_LO +: FW] & mask;
	assign fall_step = steps[lsa_pkg::STEP_FALL_LO +: FW] & mask;
	assign rise_ival = ivals[lsa_pkg::IVAL_RISE_LO +: IW];
	assign fall_ival = ivals[lsa_pkg::IVAL_FALL_LO +: IW];

	// Sums wrap on purpose: an oversized step overflows and keeps sweeping
	assign sum_up = acc + rise_step;
	assign diff_dn = acc - fall_step;
	assign above_start = acc - start_pt;
	assign wrap_now = step && (state == lsa_pkg::LSA_RISE) && (sum_up < acc);

	always_comb
	begin
		next_state = state;
		next_acc = acc;
		tmr_load = 1'b0;
		load_fall = 1'b0;
		if (!sweep_en || (mode == lsa_pkg::MODE_OFF))
		begin
			next_state = lsa_pkg::LSA_IDLE;
		end
		else
		begin
			unique case (state)
				lsa_pkg::LSA_IDLE, lsa_pkg::LSA_DONE:
				begin
					if (trig)
					begin
						tmr_load = 1'b1;
						if (mode == lsa_pkg::MODE_DOWN)
						begin
							next_acc = end_pt;
							next_state = lsa_pkg::LSA_FALL;
							load_fall = 1'b1;
						end
						else
						begin
							next_acc = start_pt;
							next_state = lsa_pkg::LSA_RISE;
						end
					end
				end
				lsa_pkg::LSA_RISE:
				begin
					if (mode == lsa_pkg::MODE_DOWN)
					begin
						// Direction change turns back from the present value
						next_state = lsa_pkg::LSA_FALL;
						tmr_load = 1'b1;
						load_fall = 1'b1;
					end
					else if (step)
					begin
						if ((sum_up >= end_pt) && (sum_up >= acc))
						begin
							if (mode == lsa_pkg::MODE_BIDIR)
							begin
								next_acc = end_pt;
								next_state = lsa_pkg::LSA_FALL;
								tmr_load = 1'b1;
								load_fall = 1'b1;
							end
							else
							begin
								next_acc = no_dwell ? 32'h0000_0000 : end_pt;
								next_state = lsa_pkg::LSA_DONE;
							end
						end
						else
						begin
							next_acc = sum_up;
						end
					end
				end
				lsa_pkg::LSA_FALL:
				begin
					if (mode == lsa_pkg::MODE_UP)
					begin
						next_state = lsa_pkg::LSA_RISE;
						tmr_load = 1'b1;
					end
					else if (step)
					begin
						if ((acc <= start_pt) || (above_start <= fall_step))
						begin
							next_acc = start_pt;
							next_state = lsa_pkg::LSA_DONE;
						end
						else
						begin
							next_acc = diff_dn;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= lsa_pkg::LSA_IDLE;
			acc <= 32'h0000_0000;
		end
		else if (ce)
		begin
			if (aux_clr.clr)
			begin
				state <= lsa_pkg::LSA_IDLE;
				acc <= 32'h0000_0000;
			end
			else
			begin
				state <= next_state;
				acc <= next_acc;
			end
		end
	end

	// Timer paces whichever direction is active
	assign tmr_run = !aux_clr.clr &&
		((state == lsa_pkg::LSA_RISE) || (state == lsa_pkg::LSA_FALL) || tmr_load);
	always_comb
	begin
		if (tmr_load)
			tmr_ival = load_fall ? fall_ival : rise_ival;
		else if (state == lsa_pkg::LSA_FALL)
			tmr_ival = fall_ival;
		else
			tmr_ival = rise_ival;
	end

	lsa_rate_timer #(
		.WIDTH(IW)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.run(tmr_run),
		.load(tmr_load),
		.interval(tmr_ival),
		.step(step)
	);

	// Each accumulator has its own clear path; they never interact
	assign aux_clr.cont = control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_CONT_CLR_AUX];
	assign aux_clr.auto_en = control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_AUTO_CLR_AUX];
	assign aux_clr.evt = clr_evt_q;
	assign ph_clr.cont = control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_CONT_CLR_PHASE];
	assign ph_clr.auto_en = control_function_reg_one[lsa_pkg::CONTROL_FUNCTION_REG_ONE_AUTO_CLR_PHASE];
	assign ph_clr.evt = clr_evt_q;

	lsa_clear_ctrl u_aux_clr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.port(aux_clr)
	);

	lsa_clear_ctrl u_ph_clr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.port(ph_clr)
	);

	// Phase clear leaves straight from the controller's flip-flop
	assign phase_acc_clear = ph_clr.clr;

	// Outputs to the synthesizer core
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			freq_word_out <= 32'h0000_0000;
			phase_word_out <= 14'h0000;
		end
		else if (ce)
		begin
			if (sweep_en && !is_phase)
				freq_word_out <= tuning_word + acc;
			else
				freq_word_out <= tuning_word;
			if (sweep_en && is_phase)
				phase_word_out <= phase_offset_word + acc[FW-1 -: PW];
			else
				phase_word_out <= phase_offset_word;
		end
	end

	// Status, all registered
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aux_acc_out <= 32'h0000_0000;
			profile_active <= 3'h0;
			sweep_running <= 1'b0;
			sweep_falling <= 1'b0;
			sweep_complete <= 1'b0;
		end
		else if (ce)
		begin
			aux_acc_out <= acc;
			profile_active <= prof_sel;
			sweep_running <= (state == lsa_pkg::LSA_RISE) || (state == lsa_pkg::LSA_FALL);
			sweep_falling <= (state == lsa_pkg::LSA_FALL);
			sweep_complete <= (state == lsa_pkg::LSA_DONE);
		end
	end

	// Overflow warning; a wrap in the same cycle as the strobe is kept
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			aux_wrapped <= 1'b0;
		else if (ce)
		begin
			if (wrap_now)
				aux_wrapped <= 1'b1;
			else if (register_transfer_strobe)
				aux_wrapped <= 1'b0;
		end
	end
endmodule

// ==== sim/lsa_host_model.sv ====
// Host side model: drives the profile pins and the update strobe
`timescale 1ns/1ps
module lsa_host_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [2:0] pins_req,
	input wire logic strobe_req,
	input wire logic slow,
	output logic [2:0] profile_select_pins = 3'h0,
	output logic register_transfer_strobe = 1'b0
);
	logic [2:0] pins_q;
	logic strobe_q;
	// A slow host lands each request one cycle later; pins still move only off the sampling edge
	always @(negedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pins_q <= 3'h0;
			strobe_q <= 1'b0;
			profile_select_pins <= 3'h0;
			register_transfer_strobe <= 1'b0;
		end
		else
		begin
			pins_q <= pins_req;
			strobe_q <= strobe_req;
			profile_select_pins <= slow ? pins_q : pins_req;
			register_transfer_strobe <= slow ? strobe_q : strobe_req;
		end
	end
endmodule

// ==== sim/lsa_sweep_props.sv ====
// Port level properties of the sweep engine
`timescale 1ns/1ps
module lsa_sweep_props (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [31:0] control_function_reg_one_in,
	input wire logic [63:0] sweep_limits,
	input wire logic register_transfer_strobe,
	input wire logic [31:0] tuning_word,
	input wire logic [13:0] phase_offset_word,
	input wire logic [31:0] freq_word_out,
	input wire logic [13:0] phase_word_out,
	input wire logic [31:0] aux_acc_out,
	input wire logic sweep_running,
	input wire logic sweep_falling,
	input wire logic sweep_complete,
	input wire logic phase_acc_clear
);
	logic [31:0] act;
	logic en_frq;
	logic en_phs;
	logic [31:0] lim;
	logic [31:0] msk;
	// Shadow of the active control word, taken on the same strobe as the design
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			act <= lsa_pkg::CONTROL_FUNCTION_REG_ONE_RESET;
			lim <= 32'h0000_0000;
		end
		else if (ce && register_transfer_strobe)
		begin
			act <= control_function_reg_one_in;
			lim <= sweep_limits[31:0];
		end
	end
	assign msk = (act[13:12] == lsa_pkg::DEST_PHASE) ? lsa_pkg::PHASE_MASK : lsa_pkg::FREQ_MASK;
	assign en_frq = act[11] && act[13:12] != lsa_pkg::DEST_PHASE;
	assign en_phs = act[11] && act[13:12] == lsa_pkg::DEST_PHASE;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	property p_freq_pass;
		ce && !en_frq && $past(rst_n) |=> freq_word_out == $past(tuning_word);
	endproperty
	a_freq_pass: assert property (p_freq_pass) else $error("freq word altered");
	property p_phase_pass;
		ce && !en_phs && $past(rst_n) |=> phase_word_out == $past(phase_offset_word);
	endproperty
	a_phase_pass: assert property (p_phase_pass) else $error("phase word altered");
	property p_freq_sum;
		ce && en_frq |=> freq_word_out == $past(tuning_word) + aux_acc_out;
	endproperty
	a_freq_sum: assert property (p_freq_sum) else $error("sweep not added to freq word");
	property p_off_idle;
		(ce && !act[11]) [*3] |-> !sweep_running;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("sweep runs while disabled");
	property p_cont_aux;
		(ce && act[18]) [*4] |-> aux_acc_out == 32'h0 && !sweep_running;
	endproperty
	a_cont_aux: assert property (p_cont_aux) else $error("aux not held clear");
	property p_cont_phase;
		(ce && act[19]) [*2] |-> phase_acc_clear;
	endproperty
	a_cont_phase: assert property (p_cont_phase) else $error("phase not held clear");
	property p_auto_phase;
		ce && register_transfer_strobe && control_function_reg_one_in[15] && !control_function_reg_one_in[19] |-> ##[1:3] phase_acc_clear;
	endproperty
	a_auto_phase: assert property (p_auto_phase) else $error("no clear pulse");
	property p_auto_stop;
		(ce && !act[15] && !act[19]) [*4] |-> !phase_acc_clear;
	endproperty
	a_auto_stop: assert property (p_auto_stop) else $error("clear without enable");
	property p_state;
		$rose(sweep_complete) && $past(sweep_falling) |-> aux_acc_out == (lim & msk);
	endproperty
	a_state: assert property (p_state) else $error("fall did not end at start");
	c_done: cover property (sweep_complete);
	c_fall: cover property (sweep_falling);
	c_clr: cover property (phase_acc_clear);
endmodule
bind lsa_sweep lsa_sweep_props lsa_sweep_props_inst (.core_clk(core_clk), .rst_n(rst_n),
	.ce(ce), .control_function_reg_one_in(control_function_reg_one_in), .sweep_limits(sweep_limits),
	.register_transfer_strobe(register_transfer_strobe),
	.tuning_word(tuning_word), .phase_offset_word(phase_offset_word),
	.freq_word_out(freq_word_out), .phase_word_out(phase_word_out), .aux_acc_out(aux_acc_out),
	.sweep_running(sweep_running), .sweep_falling(sweep_falling),
	.sweep_complete(sweep_complete), .phase_acc_clear(phase_acc_clear));

// ==== sim/tb_linear_sweep_accumulator.sv ====
// Self-checking bench for the sweep engine
`timescale 1ns/1ps
module tb_linear_sweep_accumulator;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [31:0] control_function_reg_one_in = 32'h0;
	logic [63:0] sweep_limits = 64'h0;
	logic [63:0] sweep_step_words = 64'h0;
	logic [31:0] sweep_step_intervals = 32'h0;
	logic [2:0] pins_req = 3'h0;
	logic strobe_req = 1'b0;
	logic slow = 1'b0;
	logic parallel_port_mode = 1'b0;
	logic [31:0] tuning_word = 32'h0;
	logic [13:0] phase_offset_word = 14'h0;
	logic register_transfer_strobe;
	logic [2:0] profile_select_pins;
	logic [31:0] freq_word_out;
	logic [13:0] phase_word_out;
	logic [31:0] aux_acc_out;
	logic [2:0] profile_active;
	logic sweep_running;
	logic sweep_falling;
	logic sweep_complete;
	logic aux_wrapped;
	logic phase_acc_clear;
	integer seed = 32'h563FC551;
	integer failures = 0;
	integer samples_checked = 0;
	integer cycles = 0;
	integer i;
	integer n;
	integer cnt;
	logic [31:0] st;
	logic [31:0] sp;
	logic [31:0] ev;
	logic [13:0] pe;
	logic [15:0] nv;
	always #25 core_clk = ~core_clk;
	lsa_host_model lsa_host_model_inst (.core_clk(core_clk), .rst_n(rst_n), .pins_req(pins_req),
		.strobe_req(strobe_req), .slow(slow), .profile_select_pins(profile_select_pins),
		.register_transfer_strobe(register_transfer_strobe));
	lsa_sweep lsa_sweep_inst (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .control_function_reg_one_in(control_function_reg_one_in),
		.sweep_limits(sweep_limits), .sweep_step_words(sweep_step_words),
		.sweep_step_intervals(sweep_step_intervals),
		.register_transfer_strobe(register_transfer_strobe),
		.profile_select_pins(profile_select_pins), .parallel_port_mode(parallel_port_mode),
		.tuning_word(tuning_word), .phase_offset_word(phase_offset_word),
		.freq_word_out(freq_word_out), .phase_word_out(phase_word_out),
		.aux_acc_out(aux_acc_out), .profile_active(profile_active),
		.sweep_running(sweep_running), .sweep_falling(sweep_falling),
		.sweep_complete(sweep_complete), .aux_wrapped(aux_wrapped),
		.phase_acc_clear(phase_acc_clear));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input integer k);
		repeat (k) @(negedge core_clk);
	endtask
	// Requests to the host model go by non-blocking writes so it never races the bench
	task automatic strobe(input logic [31:0] cfg);
		control_function_reg_one_in = cfg;
		strobe_req <= 1'b1;
		tick(1);
		strobe_req <= 1'b0;
	endtask
	task automatic measure(output integer c);
		c = 0;
		while (sweep_running !== 1'b1 && c < 50)
		begin
			c++;
			tick(1);
		end
		c = 0;
		while (sweep_complete !== 1'b1 && c < 3000)
		begin
			c++;
			tick(1);
		end
	endtask
	task automatic count_hi(input logic which, output integer c);
		c = 0;
		repeat (6)
		begin
			tick(1);
			c += which ? sweep_running : phase_acc_clear;
		end
	endtask
	// The first step waits one extra cycle after the trigger, and again after a turn
	function automatic integer exp_cycles(input integer steps, input integer ivl,
		input integer up_steps, input integer up_ivl);
		return steps * ivl + 1 + ((up_steps > 0) ? up_steps * up_ivl + 1 : 0);
	endfunction
	task automatic summarize();
		$display("comparisons %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			summarize();
		end
	end
	initial
	begin
		tick(4);
		rst_n = 1'b1;
		pins_req <= 3'h4;
		tick(4);
		check("pin source", profile_active, 3'h4);
		parallel_port_mode = 1'b1;
		tick(3);
		check("parallel source", profile_active, 3'h0);
		parallel_port_mode = 1'b0;
		strobe(32'h0860_0000);
		tick(3);
		check("internal source", profile_active, 3'h6);
		for (i = 0; i < 6; i++)
		begin
			// Values sit in the top 14 bits so phase sweeps are exact
			st = ($random(seed) & 32'hFF) << 18;
			sp = (($random(seed) & 32'h3F) + 1) << 18;
			n = ($random(seed) & 3) + 1;
			nv = (i == 0) ? 16'h1 : 16'(16'h1 + ($random(seed) & 7));
			tuning_word = $random(seed);
			phase_offset_word = 14'($random(seed));
			slow = i[1];
			sweep_limits = {st + sp * n, st};
			sweep_step_words = i[0] ? {sp, sp << 1} : {sp << 1, sp};
			sweep_step_intervals = i[0] ? {nv, nv + 16'h3} : {nv + 16'h3, nv};
			strobe(32'h800 | ((i == 2) ? 32'h1000 : 32'h0) | ((i == 4) ? 32'h100 : 32'h0));
			// Last pass runs both ways: up on the rising words, back on the falling ones
			pins_req <= (i == 5) ? 3'h3 : (i[0] ? 3'h2 : 3'h1);
			measure(cnt);
			check("step cycles", cnt, exp_cycles(n, nv, (i == 5) ? (n + 1) / 2 : 0, nv + 3));
			tick(2);
			ev = (i == 4) ? 32'h0 : (i[0] ? st : st + sp * n);
			pe = phase_offset_word + ((i == 2) ? ev[31:18] : 14'h0);
			check("acc end", aux_acc_out, ev);
			check("freq out", freq_word_out, tuning_word + ((i == 2) ? 32'h0 : ev));
			check("phase out", phase_word_out, pe);
			check("no wrap", aux_wrapped, 1'b0);
			pins_req <= 3'h4;
			tick(4);
		end
		strobe(32'h0004_8800);
		count_hi(1'b0, cnt);
		check("auto clear", cnt, 1);
		check("aux held", aux_acc_out, 32'h0);
		pins_req <= 3'h1;
		count_hi(1'b0, cnt);
		check("profile clear", cnt, 1);
		strobe(32'h0008_0000);
		tick(3);
		check("cont clear", phase_acc_clear, 1'b1);
		strobe(32'h0000_0A00);
		measure(cnt);
		count_hi(1'b1, cnt);
		check("level restart", cnt > 0, 1'b1);
		summarize();
	end
endmodule
